// >>> inc/cms_consts.svh
// constants for the configuration mode select and access policy block
// assumes inclusion by the core module only
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH
`define CMS_MODE_MSER 3'h0
`define CMS_MODE_MSPI 3'h1
`define CMS_MODE_MPF 3'h2
`define CMS_MODE_MPAR 3'h4
`define CMS_MODE_JTAG 3'h5
`define CMS_MODE_SPAR 3'h6
`define CMS_MODE_SSER 3'h7
`define CMS_INIT_NS 1000
`define CMS_INIT_CYC ((`CMS_INIT_NS + 9) / 10)
`define CMS_CLK_DIV 4
`define CMS_ERR_CRC 0
`define CMS_ERR_ENC 1
`define CMS_ERR_MODE 2
`define CMS_ERR_ABORT 3
`endif

// >>> inc/cms_pkg.sv
// types for the configuration mode select and access policy block
// assumes cms_consts.svh is on the include path
package cms_pkg;
  typedef enum logic [1:0] {
    CMS_DIR_OUT,
    CMS_DIR_IN,
    CMS_DIR_NONE
  } cms_dir_t;
  typedef struct packed {
    logic [2:0] mode;
    logic [5:0] widths;
    cms_dir_t clk_dir;
    logic is_spi;
  } cms_mode_t;
  typedef struct packed {
    logic master_full;
    logic master_local;
    logic slave_local;
  } cms_access_t;
  typedef struct packed {
    logic init_done;
    logic done;
    logic [3:0] err;
  } cms_status_t;
endpackage

// >>> core/cms_core.sv
// configuration front end: mode decode, access policy, init and done status
// assumes pin inputs are asynchronous; link logic runs on i_cfg_clk
//
// Overview of operation
// - decode mode pins into seven modes
// - master modes drive clock, slave modes receive
// - slave parallel wide refuses encrypted bitstreams
// - undriven mode pins select slave serial
// - master region controls global configuration
// - jtag pins block master port cross-region
// - spi limits master port to master region
// - spi x2/x4 disables slave region ports
// - jtag path stays available always
// - init pin released high after initialization
// - crc mismatch drives init pin low
// - failure causes held in status register
// - single die port reaches whole device
`timescale 1ns/1ps
`include "cms_consts.svh"
module cms_core #(
  parameter int INIT_CYC = `CMS_INIT_CYC,
  parameter int CLK_DIV = `CMS_CLK_DIV
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cfg_clk,
  input wire logic [2:0] i_mode_pins,
  input wire logic i_stacked,
  input wire logic i_restart,
  input wire logic [1:0] i_width_sel,
  input wire logic i_encrypted,
  input wire logic i_word_valid,
  input wire logic i_crc_error,
  input wire logic i_last_word,
  input wire logic i_jtag_req,
  output logic o_jtag_grant,
  output cms_pkg::cms_mode_t o_mode,
  output cms_pkg::cms_access_t o_access,
  output logic o_master_global,
  output logic o_cfg_clk_out,
  output logic o_cfg_clk_oe,
  output logic o_init_n_out,
  output logic o_init_n_oe,
  output cms_pkg::cms_status_t o_status,
  output logic o_word_accept
);
  import cms_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // link side: words and crc results arrive on the configuration clock
  // the accept level from the system side passes three flops here; a word
  // counts only while the last two copies are both high
  typedef struct packed {
    logic [2:0] en_sync;
    logic evt_tgl;
    logic [2:0] evt;
  } cms_link_t;

  cms_link_t l_q;
  cms_link_t l_d;

  logic link_en;
  logic link_take;
  logic link_final;

  assign link_en = l_q.en_sync[2] & l_q.en_sync[1];
  assign link_take = link_en & i_word_valid;
  assign link_final = i_crc_error | i_last_word;

  always_comb begin
    l_d = l_q;

    // accept level from the system clock
    l_d.en_sync = {l_q.en_sync[1:0], o_word_accept};

    if (link_take && link_final) begin
      // event word: crc result, last flag and encryption travel together
      l_d.evt = {i_crc_error, i_last_word, i_encrypted};
      l_d.evt_tgl = ~l_q.evt_tgl;
    end else if (link_take && i_encrypted) begin
      // encrypted body word: only the encryption flag is reported
      l_d.evt = 3'h1;
      l_d.evt_tgl = ~l_q.evt_tgl;
    end
  end

  always_ff @(posedge i_cfg_clk or posedge i_rst) begin
    if (i_rst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system side state
  typedef enum logic [1:0] {
    ST_INIT,
    ST_LOAD,
    ST_DONE,
    ST_ERROR
  } cms_state_t;

  typedef struct packed {
    cms_state_t st;
    logic [15:0] cnt;
    logic [7:0] div;
    logic clk_out;
    logic [2:0] mode;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] tgl_s;
    logic tgl_seen;
    logic [2:0] evt;
    logic [3:0] err;
    logic init_done;
    logic done;
    logic accept;
  } cms_sys_t;

  cms_sys_t s_q;
  cms_sys_t s_d;

  logic wide_spar;
  logic evt_new;
  logic evt_stable;
  logic evt_take;
  logic init_end;
  logic bad_strap;
  logic div_wrap;

  // a link event counts once the second and third toggle copies agree;
  // the payload was set with the toggle and has long settled by then
  assign evt_new = s_q.tgl_s[2] ^ s_q.tgl_seen;
  assign evt_stable = s_q.tgl_s[2] == s_q.tgl_s[1];
  assign evt_take = evt_stable & evt_new;

  // wide slave parallel cannot decrypt
  assign wide_spar = (s_q.mode == `CMS_MODE_SPAR) && (i_width_sel != 2'h0);

  // the strap is taken only when its last two samples agree
  assign init_end = (s_q.cnt >= 16'(INIT_CYC - 1)) &&
                    (s_q.pin_s2 == s_q.pin_s3);

  // code 011 selects no mode
  assign bad_strap = (s_q.pin_s3 == 3'h3);

  assign div_wrap = (s_q.div == 8'(CLK_DIV - 1));

  always_comb begin
    s_d = s_q;

    // mode strap pins: three flops, async to this clock
    s_d.pin_s1 = i_mode_pins;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;

    // link event toggle and its payload
    s_d.tgl_s = {s_q.tgl_s[1:0], l_q.evt_tgl};
    s_d.evt = l_q.evt;
    if (evt_take) begin
      s_d.tgl_seen = s_q.tgl_s[2];
    end

    // free running divider for the master configuration clock
    if (div_wrap) begin
      s_d.div = 8'h0;
      s_d.clk_out = ~s_q.clk_out;
    end else begin
      s_d.div = s_q.div + 8'h1;
    end

    unique case (s_q.st)
      ST_INIT: begin
        s_d.cnt = s_q.cnt + 16'h1;
        if (init_end) begin
          s_d.mode = s_q.pin_s3;
          s_d.init_done = 1'b1;
          s_d.st = ST_LOAD;
          if (bad_strap) begin
            s_d.err[`CMS_ERR_MODE] = 1'b1;
            s_d.st = ST_ERROR;
          end
        end
      end
      ST_LOAD: begin
        if (evt_take) begin
          if (s_q.evt[0] && wide_spar) begin
            s_d.err[`CMS_ERR_ENC] = 1'b1;
            s_d.st = ST_ERROR;
          end else if (s_q.evt[2]) begin
            s_d.err[`CMS_ERR_CRC] = 1'b1;
            s_d.st = ST_ERROR;
          end else if (s_q.evt[1]) begin
            s_d.done = 1'b1;
            s_d.st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
      end
      ST_ERROR: begin
        s_d.done = 1'b0;
      end
    endcase

    // restart: error bits stay, a cut load is recorded as abort
    if (i_restart) begin
      if (s_q.st == ST_LOAD) begin
        s_d.err[`CMS_ERR_ABORT] = 1'b1;
      end
      s_d.st = ST_INIT;
      s_d.cnt = 16'h0;
      s_d.init_done = 1'b0;
      s_d.done = 1'b0;
    end

    // registered so the link side never sees a decode glitch
    s_d.accept = (s_d.st == ST_LOAD);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{st: ST_INIT, mode: `CMS_MODE_SSER, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode and policy
  always_comb begin
    o_mode.mode = s_q.mode;
    o_mode.is_spi = 1'b0;
    o_mode.widths = 6'h0;
    o_mode.clk_dir = CMS_DIR_NONE;
    unique case (s_q.mode)
      `CMS_MODE_MSER: begin
        o_mode.widths = 6'h01;
        o_mode.clk_dir = CMS_DIR_OUT;
      end
      `CMS_MODE_MSPI: begin
        o_mode.widths = 6'h07;
        o_mode.clk_dir = CMS_DIR_OUT;
        o_mode.is_spi = 1'b1;
      end
      `CMS_MODE_MPF, `CMS_MODE_MPAR: begin
        o_mode.widths = 6'h18;
        o_mode.clk_dir = CMS_DIR_OUT;
      end
      `CMS_MODE_JTAG: begin
        // the clock pin has no role here
        o_mode.widths = 6'h01;
        o_mode.clk_dir = CMS_DIR_NONE;
      end
      `CMS_MODE_SPAR: begin
        o_mode.widths = 6'h38;
        o_mode.clk_dir = CMS_DIR_IN;
      end
      `CMS_MODE_SSER: begin
        o_mode.widths = 6'h01;
        o_mode.clk_dir = CMS_DIR_IN;
      end
      default: begin
        o_mode.widths = 6'h0;
        o_mode.clk_dir = CMS_DIR_NONE;
      end
    endcase
  end

  always_comb begin
    o_access.master_full = 1'b1;
    o_access.master_local = 1'b1;
    o_access.slave_local = i_stacked;
    if (i_stacked) begin
      if (s_q.mode == `CMS_MODE_JTAG) begin
        o_access.master_full = 1'b0;
      end
      if (o_mode.is_spi) begin
        o_access.master_full = 1'b0;
        if (i_width_sel != 2'h0) begin
          o_access.slave_local = 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins and status
  assign o_master_global = 1'b1;
  assign o_jtag_grant = i_jtag_req;
  assign o_cfg_clk_out = s_q.clk_out;
  assign o_cfg_clk_oe = (o_mode.clk_dir == CMS_DIR_OUT) && s_q.init_done;

  // open drain: drive low until init done, and again on crc failure
  assign o_init_n_out = 1'b0;
  assign o_init_n_oe = ~s_q.init_done | s_q.err[`CMS_ERR_CRC];

  always_comb begin
    o_status.init_done = s_q.init_done;
    o_status.done = s_q.done;
    o_status.err = s_q.err;
  end

  assign o_word_accept = s_q.accept;
endmodule

// >>> testbench/cms_chk.sv
// checker of mode, access and status relations at the core ports
// assumes it is bound onto cms_core
`timescale 1ns/1ps
module cms_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_stacked,
  input wire logic i_jtag_req,
  input wire logic [1:0] i_width_sel,
  input wire logic o_jtag_grant,
  input wire logic o_cfg_clk_oe,
  input wire cms_pkg::cms_mode_t o_mode,
  input wire cms_pkg::cms_access_t o_access,
  input wire cms_pkg::cms_status_t o_status
);
  import cms_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic jtag, mst;
  assign jtag = o_mode.mode == 3'h5;
  assign mst = o_mode.mode inside {3'h0, 3'h1, 3'h2, 3'h4};
  a_grant_follows: assert property (o_jtag_grant == i_jtag_req)
    else $error("jtag grant mismatch");
  a_master_clk: assert property (mst |-> o_mode.clk_dir == CMS_DIR_OUT)
    else $error("master clock direction");
  a_slave_clk: assert property (o_mode.mode[2:1] == 2'h3 |->
    o_mode.clk_dir == CMS_DIR_IN && !o_cfg_clk_oe) else $error("slave clock");
  a_mono_full: assert property (!i_stacked |-> o_access.master_full)
    else $error("single die port limited");
  a_stack_local: assert property (i_stacked && (o_mode.is_spi || jtag)
    |-> !o_access.master_full) else $error("master port crossed regions");
  a_spi_wide: assert property (i_stacked && o_mode.is_spi && |i_width_sel
    |-> !o_access.slave_local) else $error("slave port open in wide spi");
  a_mode_hold: assert property (o_status.init_done
    && $past(o_status.init_done) |-> $stable(o_mode)) else $error("mode moved");
  a_done_clean: assert property ($rose(o_status.done) |->
    o_status.err == 4'h0) else $error("done after error");
  cover property ($rose(o_status.done));
  cover property ($rose(o_status.err[0]));
  cover property ($rose(o_status.err[1]));
endmodule
bind cms_core cms_chk cms_chk_i (.*);

// >>> testbench/cms_link_model.sv
// link agent: makes the link clock and sends bitstream words
// assumes the bench calls send only after a boot has started a load
`timescale 1ns/1ps
module cms_link_model (
  output logic o_cfg_clk,
  output logic o_word_valid,
  output logic o_encrypted,
  output logic o_crc_error,
  output logic o_last_word
);
  initial begin
    {o_cfg_clk, o_word_valid, o_encrypted, o_crc_error, o_last_word} = 5'h0;
    #3;
    forever #24 o_cfg_clk = ~o_cfg_clk;
  end
  task automatic send(input logic e, c, l);
    @(negedge o_cfg_clk);
    {o_word_valid, o_encrypted, o_crc_error, o_last_word} = {1'h1, e, c, l};
    @(negedge o_cfg_clk);
    // released qualifiers flip so a stale copy is never seen
    {o_word_valid, o_encrypted, o_crc_error, o_last_word} = {1'h0, ~e, ~c, ~l};
    repeat (2) @(negedge o_cfg_clk);
  endtask
endmodule

// >>> testbench/cms_core_test.sv
// top bench: boots every mode, loads, corrupts and aborts bitstreams
// assumes the link model drives the link clock and words
`timescale 1ns/1ps
module cms_core_test;
  import cms_pkg::*;
  logic i_sys_clk, i_rst, i_stacked, i_restart, i_jtag_req;
  logic i_cfg_clk, i_encrypted, i_word_valid, i_crc_error, i_last_word;
  logic [2:0] i_mode_pins;
  logic [1:0] i_width_sel;
  logic o_jtag_grant, o_master_global, o_cfg_clk_out, o_cfg_clk_oe;
  logic o_init_n_out, o_init_n_oe, o_word_accept;
  cms_mode_t o_mode;
  cms_access_t o_access;
  cms_status_t o_status;
  int mismatches = 0;
  int checks = 0;
  cms_core #(.INIT_CYC(4), .CLK_DIV(4)) cms_core_i (.*);
  cms_link_model cms_link_model_i (.o_cfg_clk(i_cfg_clk),
    .o_word_valid(i_word_valid), .o_encrypted(i_encrypted),
    .o_crc_error(i_crc_error), .o_last_word(i_last_word));
  task chk(string n, logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task final_report;
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task boot(logic [2:0] m);
    i_mode_pins = m;
    i_rst = 1'h1;
    repeat (10) @(negedge i_sys_clk);
    chk("rst_mode", o_mode.mode, 3'h7);
    chk("rst_init", o_init_n_oe, 1'h1);
    i_rst = 1'h0;
    for (int k = 0; k < 20 && o_status.init_done !== 1'h1; k++)
      @(negedge i_sys_clk);
    chk("init_done", o_status.init_done, 1'h1);
    if (m != 3'h3)
      chk("init_rel", o_init_n_oe, 1'h0);
    // let the accept level cross to the link side before any word
    repeat (20) @(negedge i_sys_clk);
  endtask
  task t_modes;
    logic [2:0] m;
    logic mst, spi, jt, f;
    logic [1:0] dir;
    logic [5:0] w;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      boot(m);
      if (m == 3'h3) begin
        chk("bad_mode", o_status.err[2], 1'h1);
        continue;
      end
      mst = !m[2] || m == 3'h4;
      spi = m == 3'h1;
      jt = m == 3'h5;
      dir = mst ? CMS_DIR_OUT : (m == 3'h5 ? CMS_DIR_NONE : CMS_DIR_IN);
      w = spi ? 6'h07 : (m[2:1] == 2'h3 && !m[0] ? 6'h38 : 6'h18);
      if (m == 3'h0 || m[0] && m[2]) begin
        w = 6'h01;
      end
      chk("widths", o_mode.widths, w);
      chk("mode", o_mode.mode, m);
      chk("spi", o_mode.is_spi, spi);
      chk("clk_dir", o_mode.clk_dir, dir);
      chk("clk_oe", o_cfg_clk_oe, mst);
      for (int j = 0; j < 4; j++) begin
        {i_stacked, i_width_sel[0]} = j[1:0];
        @(negedge i_sys_clk);
        f = !i_stacked || !(spi || jt);
        chk("full", o_access.master_full, f);
        chk("m_loc", o_access.master_local, 1'h1);
        if (i_stacked)
          chk("s_loc", o_access.slave_local, !(spi && i_width_sel[0]));
      end
      {i_stacked, i_width_sel} = 3'h0;
    end
  endtask
  task t_load;
    boot(3'h7);
    cms_link_model_i.send(1'h0, 1'h0, 1'h0);
    cms_link_model_i.send(1'h0, 1'h0, 1'h1);
    chk("done", o_status.done, 1'h1);
    chk("acc_off", o_word_accept, 1'h0);
    chk("err", o_status.err, 4'h0);
  endtask
  task t_crc;
    boot(3'h7);
    cms_link_model_i.send(1'h0, 1'h1, 1'h0);
    chk("crc_err", o_status.err[0], 1'h1);
    chk("crc_pin", o_init_n_oe, 1'h1);
    chk("pin_lvl", o_init_n_out, 1'h0);
    cms_link_model_i.send(1'h0, 1'h0, 1'h1);
    chk("crc_done", o_status.done, 1'h0);
  endtask
  task t_enc;
    boot(3'h6);
    cms_link_model_i.send(1'h1, 1'h0, 1'h0);
    chk("enc_x8", o_status.err[1], 1'h0);
    @(negedge i_sys_clk);
    i_width_sel = 2'h2;
    cms_link_model_i.send(1'h1, 1'h0, 1'h0);
    chk("enc_x16", o_status.err[1], 1'h1);
    @(negedge i_sys_clk);
    i_width_sel = 2'h0;
  endtask
  task t_abort;
    boot(3'h7);
    i_restart = 1'h1;
    @(negedge i_sys_clk);
    i_restart = 1'h0;
    repeat (3) @(negedge i_sys_clk);
    chk("abort", o_status.err[3], 1'h1);
  endtask
  task t_jtag;
    logic v;
    v = o_cfg_clk_out;
    repeat (4) @(negedge i_sys_clk);
    chk("config_clock_pin_tgl", o_cfg_clk_out, !v);
    i_jtag_req = 1'h1;
    @(negedge i_sys_clk);
    chk("grant", o_jtag_grant, 1'h1);
    chk("global", o_master_global, 1'h1);
    i_jtag_req = 1'h0;
    @(negedge i_sys_clk);
    chk("grant_off", o_jtag_grant, 1'h0);
  endtask
  initial begin
    i_sys_clk = 1'h0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    {i_rst, i_stacked, i_restart, i_jtag_req} = 4'h8;
    i_mode_pins = 3'h7;
    i_width_sel = 2'h0;
    t_modes;
    t_load;
    t_crc;
    t_enc;
    t_abort;
    t_jtag;
    final_report;
  end
  initial begin
    #100000;
    mismatches++;
    final_report;
  end
endmodule
